// ==== ipfs_top.sv ====
// seven-output pwm generator with phase shedding and fault supervisor
// assumes fault and supply-on pins are asynchronous, sense words on pclk
`timescale 1ns/10ps
`include "ipfs_map.svh"
module ipfs_top #(
   parameter int CS_W = 12,
   parameter int unsigned DEBOUNCE_CYC = `IPFS_DEBOUNCE_US * 1000 / `IPFS_CLK_NS,
   parameter int unsigned RESTART_CYC = `IPFS_RESTART_MS * 1000000 / `IPFS_CLK_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ipfs_pkg::ipfs_flags_t fault_pins,
   input wire logic supply_on_request,
   input wire logic [CS_W-1:0] output_current_sense,
   input wire logic [CS_W-1:0] primary_current_sense,
   output logic phase1_primary_drive,
   output logic phase1_rectifier_drive,
   output logic phase1_freewheel_drive,
   output logic phase2_primary_drive,
   output logic phase2_rectifier_drive,
   output logic phase2_freewheel_drive,
   output logic fan_drive,
   output logic oring_switch,
   output logic soft_start_go,
   output ipfs_pkg::ipfs_fmode_t filter_mode,
   output logic irq
);
   import ipfs_pkg::*;
   localparam int AVG_CYC = `IPFS_AVG_NS / `IPFS_CLK_NS;
   localparam int SUM_W = CS_W + 11;
   localparam logic [16:0] STEP = 17'(`IPFS_CLK_NS / `IPFS_RES_NS);

   // ==========================================
   // helpers
   function automatic ipfs_resp_t resp_of(logic [7:0] r, int i);
      return ipfs_resp_t'(r[2*i+:2]);
   endfunction : resp_of

   function automatic logic [15:0] clampw(logic signed [17:0] v, logic [15:0] mx);
      if (v < 0) return 16'h0000;
      if (v > $signed({2'b00, mx})) return mx;
      return v[15:0];
   endfunction : clampw

   function automatic logic in_win(logic [15:0] c, ipfs_edge_t e, logic [15:0] w);
      return c >= e.rise && {1'b0, c} < {1'b0, e.fall} + {1'b0, w};
   endfunction : in_win

   // ==========================================
   // registers
   logic [3:0] ctrl_reg;
   logic [15:0] period_reg, demand_reg, maxw_reg, minw_reg;
   logic [CS_W-1:0] ll_exit_reg, ll_enter_reg;
   logic [31:0] deb_reg, rdly_reg;
   logic [7:0] resp_reg;
   logic [3:0] status_reg, status_next, mask_reg, first_reg, first_next;
   logic [4:0] trans_reg;
   logic [3:0] bal_reg;
   ipfs_edge_t edge_reg [7];
   logic [31:0] prdata_reg, rdata_next;
   logic pready_reg, pslverr_reg, irq_reg;

   // ==========================================
   // apb slave: no wait states, answer registered in setup
   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready_reg & pwrite;
   wire mapped = paddr[1:0] == 2'b00 && paddr <= `IPFS_A_EDGE6;
   wire is_edge = paddr >= `IPFS_A_EDGE0 && mapped;
   wire [2:0] eidx = 3'(paddr[7:2] - 6'h10);
   wire [3:0] w1c = (wr_en && paddr == `IPFS_A_STATUS) ? pwdata[3:0] : 4'h0;

   ipfs_state_t st_reg;
   logic light_reg, oring_reg, soft_reg, tdone_reg;
   logic [SUM_W-1:0] sum_reg, sum_last_reg;
   ipfs_fmode_t fmode_reg;

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (is_edge) begin
         rdata_next = edge_reg[eidx];
      end else begin
         unique case (paddr)
            `IPFS_A_CTRL: rdata_next[3:0] = ctrl_reg;
            `IPFS_A_PERIOD: rdata_next[15:0] = period_reg;
            `IPFS_A_DEMAND: rdata_next[15:0] = demand_reg;
            `IPFS_A_MAXW: rdata_next[15:0] = maxw_reg;
            `IPFS_A_MINW: rdata_next[15:0] = minw_reg;
            `IPFS_A_LL_EXIT: rdata_next[CS_W-1:0] = ll_exit_reg;
            `IPFS_A_LL_ENTER: rdata_next[CS_W-1:0] = ll_enter_reg;
            `IPFS_A_DEBOUNCE: rdata_next = deb_reg;
            `IPFS_A_RESTART: rdata_next = rdly_reg;
            `IPFS_A_RESP: rdata_next[7:0] = resp_reg;
            `IPFS_A_STATUS: rdata_next[3:0] = status_reg;
            `IPFS_A_MASK: rdata_next[3:0] = mask_reg;
            `IPFS_A_FIRST: rdata_next[3:0] = first_reg;
            `IPFS_A_STATE: rdata_next = {1'b0, sum_last_reg[SUM_W-1:SUM_W-23], 2'b00,
               fmode_reg, 2'(st_reg), oring_reg, light_reg};
            `IPFS_A_TRANS: rdata_next[4:0] = trans_reg;
            `IPFS_A_BAL: rdata_next[3:0] = bal_reg;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         if (setup) prdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 4'h0;
         period_reg <= `IPFS_PERIOD_RST;
         demand_reg <= 16'h0000;
         maxw_reg <= `IPFS_MAXW_RST;
         minw_reg <= `IPFS_MINW_RST;
         ll_exit_reg <= CS_W'(`IPFS_LL_EXIT_RST);
         ll_enter_reg <= CS_W'(`IPFS_LL_ENTER_RST);
         deb_reg <= DEBOUNCE_CYC;
         rdly_reg <= RESTART_CYC;
         resp_reg <= `IPFS_RESP_RST;
         mask_reg <= 4'h0;
         trans_reg <= `IPFS_TRANS_RST;
         bal_reg <= `IPFS_BAL_RST;
         for (int i = 0; i < 7; i++) edge_reg[i] <= '0;
      end else if (wr_en && is_edge) begin
         edge_reg[eidx] <= pwdata;
      end else if (wr_en) begin
         unique case (paddr)
            `IPFS_A_CTRL: ctrl_reg <= pwdata[3:0];
            `IPFS_A_PERIOD: period_reg <= pwdata[15:0];
            `IPFS_A_DEMAND: demand_reg <= pwdata[15:0];
            `IPFS_A_MAXW: maxw_reg <= pwdata[15:0];
            `IPFS_A_MINW: minw_reg <= pwdata[15:0];
            `IPFS_A_LL_EXIT: ll_exit_reg <= pwdata[CS_W-1:0];
            `IPFS_A_LL_ENTER: ll_enter_reg <= pwdata[CS_W-1:0];
            `IPFS_A_DEBOUNCE: deb_reg <= pwdata;
            `IPFS_A_RESTART: rdly_reg <= pwdata;
            `IPFS_A_RESP: resp_reg <= pwdata[7:0];
            `IPFS_A_MASK: mask_reg <= pwdata[3:0];
            `IPFS_A_TRANS: trans_reg <= pwdata[4:0];
            `IPFS_A_BAL: bal_reg <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // fault supervisor
   logic [3:0] f_s1, f_s2, hold_reg, tripped, shut_mask, ring_mask, pwm_mask;
   logic [31:0] dcnt_reg [4];
   logic son_s1, son_s2;
   logic restart;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_s1 <= 4'h0;
         f_s2 <= 4'h0;
         son_s1 <= 1'b0;
         son_s2 <= 1'b0;
      end else begin
         f_s1 <= fault_pins;
         f_s2 <= f_s1;
         son_s1 <= supply_on_request;
         son_s2 <= son_s1;
      end
   end

   genvar g;
   for (g = 0; g < 4; g++) begin : g_flag
      assign tripped[g] = f_s2[g] && dcnt_reg[g] >= deb_reg;
      assign shut_mask[g] = resp_of(resp_reg, g) == RESP_SHUT;
      assign ring_mask[g] = resp_of(resp_reg, g) == RESP_ORING;
      assign pwm_mask[g] = resp_of(resp_reg, g) == RESP_PWM;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) dcnt_reg[g] <= 32'h0000_0000;
         else if (!f_s2[g]) dcnt_reg[g] <= 32'h0000_0000;
         else if (dcnt_reg[g] < deb_reg) dcnt_reg[g] <= dcnt_reg[g] + 32'h1;
      end
   end

   // sticky flags, a new detection beats a clear in the same cycle
   assign status_next = (status_reg & ~w1c) | f_s2;
   // lowest-numbered flag wins a tie
   assign first_next = (first_reg == 4'h0) ? 4'(f_s2 & (~f_s2 + 4'h1))
                     : (status_next == 4'h0) ? 4'h0 : first_reg;
   wire [3:0] hold_next = (hold_reg | tripped) & ~(w1c & ~tripped)
                        & ~(restart ? shut_mask : 4'h0);
   wire oring_cut = |(hold_reg & (ring_mask | shut_mask));
   wire pwm_cut = |(hold_reg & (pwm_mask | shut_mask));
   wire shut_trip = |(tripped & ~hold_reg & shut_mask);
   wire on_ok = son_s2 & ctrl_reg[`IPFS_CTRL_ON];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 4'h0;
         first_reg <= 4'h0;
         hold_reg <= 4'h0;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         first_reg <= first_next;
         hold_reg <= hold_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   // ==========================================
   // supply sequencing
   logic [31:0] rcnt_reg;
   ipfs_state_t st_next;
   logic go;
   always_comb begin
      st_next = st_reg;
      go = 1'b0;
      restart = 1'b0;
      unique case (st_reg)
         ST_OFF: begin
            if (on_ok) begin
               st_next = ST_RUN;
               go = 1'b1;
            end
         end
         ST_RUN: begin
            if (shut_trip) st_next = ST_WAIT;
            else if (!on_ok) st_next = ST_OFF;
         end
         ST_WAIT: begin
            if (rcnt_reg >= rdly_reg) begin
               restart = 1'b1;
               go = on_ok;
               st_next = on_ok ? ST_RUN : ST_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= ST_OFF;
         rcnt_reg <= 32'h0000_0000;
         soft_reg <= 1'b0;
         oring_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         rcnt_reg <= (st_reg == ST_WAIT) ? rcnt_reg + 32'h1 : 32'h0000_0000;
         soft_reg <= go;
         oring_reg <= st_next == ST_RUN && !oring_cut;
      end
   end

   // ==========================================
   // switching counter, 5 ns units advanced per clock
   logic [15:0] cnt_reg;
   wire wrap = {1'b0, cnt_reg} + STEP >= {1'b0, period_reg};
   wire [15:0] half = period_reg >> 1;
   // phase two runs half a period behind phase one
   wire [15:0] ph2 = cnt_reg >= half ? cnt_reg - half : cnt_reg + half;

   // ==========================================
   // load averaging and phase shedding
   logic [10:0] wcnt_reg;
   wire wend = wcnt_reg == 11'(AVG_CYC - 1);
   wire [SUM_W-1:0] total = sum_reg + SUM_W'(output_current_sense);
   wire [SUM_W-1:0] exit_thr = SUM_W'(ll_exit_reg * AVG_CYC);
   wire [SUM_W-1:0] enter_thr = SUM_W'(ll_enter_reg * AVG_CYC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wcnt_reg <= 11'h000;
         sum_reg <= '0;
         sum_last_reg <= '0;
         light_reg <= 1'b1;
      end else if (wend) begin
         wcnt_reg <= 11'h000;
         sum_reg <= '0;
         sum_last_reg <= total;
         if (total > exit_thr) light_reg <= 1'b0;
         else if (total < enter_thr) light_reg <= 1'b1;
      end else begin
         wcnt_reg <= wcnt_reg + 11'h001;
         sum_reg <= total;
      end
   end

   // ==========================================
   // pulse width, balance and skipping
   logic [15:0] w1_reg, w2_reg, fanw_reg;
   logic skip_reg;
   logic [CS_W-1:0] i1_reg, i2_reg;
   logic [6:0] out_reg;
   wire [15:0] wbase = demand_reg > maxw_reg ? maxw_reg : demand_reg;
   wire signed [17:0] diff = $signed({6'h00, i1_reg}) - $signed({6'h00, i2_reg});
   wire signed [17:0] adj = ctrl_reg[`IPFS_CTRL_BAL] ? diff >>> bal_reg : 18'sh0;
   wire signed [17:0] wb_s = $signed({2'b00, wbase});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 16'h0000;
         w1_reg <= 16'h0000;
         w2_reg <= 16'h0000;
         fanw_reg <= 16'h0000;
         skip_reg <= 1'b0;
         i1_reg <= '0;
         i2_reg <= '0;
      end else begin
         cnt_reg <= wrap ? 16'h0000 : 16'(cnt_reg + STEP);
         // widths only change at a period boundary to avoid runt pulses
         if (wrap) begin
            w1_reg <= clampw(wb_s - adj, maxw_reg);
            w2_reg <= clampw(wb_s + adj, maxw_reg);
            fanw_reg <= wbase;
            skip_reg <= ctrl_reg[`IPFS_CTRL_SKIP] && demand_reg < minw_reg;
         end
         // primary current sampled as each primary pulse ends
         if (out_reg[0] && !in_win(cnt_reg, edge_reg[0], w1_reg))
            i1_reg <= primary_current_sense;
         if (out_reg[3] && !in_win(ph2, edge_reg[3], w2_reg))
            i2_reg <= primary_current_sense;
      end
   end

   // ==========================================
   // seven outputs: 0-2 phase one, 3-5 phase two, 6 fan
   wire run = st_reg == ST_RUN && !pwm_cut;
   for (g = 0; g < 7; g++) begin : g_out
      localparam bit P2 = g >= 3 && g < 6;
      localparam bit SR = g == 1 || g == 2 || g == 4 || g == 5;
      wire [15:0] pos = P2 ? ph2 : cnt_reg;
      wire [15:0] wid = g == 6 ? fanw_reg : P2 ? w2_reg : w1_reg;
      wire en = run && (g == 6 || !skip_reg)
         && !(P2 && light_reg)
         && !(SR && ctrl_reg[`IPFS_CTRL_SROFF]);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) out_reg[g] <= 1'b0;
         else out_reg[g] <= en && in_win(pos, edge_reg[g], wid);
      end
   end

   // ==========================================
   // compensation filter mode hand-over
   logic [4:0] tcnt_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcnt_reg <= 5'h00;
         tdone_reg <= 1'b0;
         fmode_reg <= FM_SOFT;
      end else begin
         if (!oring_reg) begin
            tcnt_reg <= 5'h00;
            tdone_reg <= 1'b0;
         end else if (wrap && !tdone_reg) begin
            if (tcnt_reg == trans_reg) tdone_reg <= 1'b1;
            else tcnt_reg <= tcnt_reg + 5'h01;
         end
         fmode_reg <= !oring_reg || !tdone_reg ? FM_SOFT
                    : light_reg ? FM_LIGHT : FM_NORMAL;
      end
   end

   // ==========================================
   // outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   // output to switch mapping is fixed
   assign {fan_drive, phase2_freewheel_drive, phase2_rectifier_drive, phase2_primary_drive,
           phase1_freewheel_drive, phase1_rectifier_drive, phase1_primary_drive} = out_reg;
   assign oring_switch = oring_reg;
   assign soft_start_go = soft_reg;
   assign filter_mode = fmode_reg;
   assign irq = irq_reg;

   // ==========================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_phase2_shed: assert property (
      phase2_primary_drive |-> !$past(light_reg)) else $error("phase two on in light load");
   chk_light_exit: assert property (
      wend && total > exit_thr |=> !light_reg) else $error("light load not left");
   chk_shed_hyst: assert property (
      wend && total >= enter_thr && total <= exit_thr |=> $stable(light_reg))
      else $error("shedding hysteresis broken");
   chk_pwm_action: assert property (
      $rose(hold_reg[0]) && pwm_mask[0] |=> out_reg == 7'h00) else $error("pwm not cut");
   chk_debounce_wait: assert property (
      $rose(hold_reg[1]) |-> $past(f_s2[1] && dcnt_reg[1] >= deb_reg))
      else $error("action before debounce");
   chk_restart_delay: assert property (
      $rose(soft_start_go) && $past(st_reg) == ST_WAIT |-> $past(rcnt_reg) >= rdly_reg)
      else $error("restart too early");
   chk_first_hold: assert property (
      first_reg != 4'h0 && status_next != 4'h0 |=> $stable(first_reg) && $onehot(first_reg))
      else $error("first flag changed");
   chk_max_width: assert property (
      $past(wrap) |-> w1_reg <= $past(maxw_reg) && w2_reg <= $past(maxw_reg))
      else $error("width above limit");
   chk_skip_pulse: assert property (
      skip_reg && $past(skip_reg) |-> !phase1_primary_drive && !phase2_primary_drive)
      else $error("pulse not skipped");
   chk_sr_off: assert property (
      $past(ctrl_reg[`IPFS_CTRL_SROFF]) |-> !phase1_rectifier_drive && !phase1_freewheel_drive
         && !phase2_rectifier_drive && !phase2_freewheel_drive)
      else $error("rectifier not disabled");
   chk_flag_sticky: assert property (
      status_reg[0] && !w1c[0] |=> status_reg[0]) else $error("flag lost");
   chk_filter_soft: assert property (
      !oring_reg |=> filter_mode == FM_SOFT) else $error("filter left soft early");

   cov_phase2_on: cover property ($fell(light_reg));
   cov_hiccup: cover property (st_reg == ST_WAIT ##1 st_reg == ST_RUN);
   cov_skip: cover property (skip_reg && st_reg == ST_RUN);
   cov_filter_normal: cover property (filter_mode == FM_NORMAL);
endmodule : ipfs_top

// ==== ipfs_map.svh ====
// offsets, field positions, reset values and timing for the pwm supervisor
// assumes a 32-bit apb slave with an 8-bit byte address
`ifndef IPFS_MAP_SVH
`define IPFS_MAP_SVH
// ==========================================
// register byte offsets
`define IPFS_A_CTRL 8'h00
`define IPFS_A_PERIOD 8'h04
`define IPFS_A_DEMAND 8'h08
`define IPFS_A_MAXW 8'h0c
`define IPFS_A_MINW 8'h10
`define IPFS_A_LL_EXIT 8'h14
`define IPFS_A_LL_ENTER 8'h18
`define IPFS_A_DEBOUNCE 8'h1c
`define IPFS_A_RESTART 8'h20
`define IPFS_A_RESP 8'h24
`define IPFS_A_STATUS 8'h28
`define IPFS_A_MASK 8'h2c
`define IPFS_A_FIRST 8'h30
`define IPFS_A_STATE 8'h34
`define IPFS_A_TRANS 8'h38
`define IPFS_A_BAL 8'h3c
`define IPFS_A_EDGE0 8'h40
`define IPFS_A_EDGE6 8'h58
// ==========================================
// control fields
`define IPFS_CTRL_ON 0
`define IPFS_CTRL_SKIP 1
`define IPFS_CTRL_SROFF 2
`define IPFS_CTRL_BAL 3
// ==========================================
// reset values
`define IPFS_PERIOD_RST 16'h0540
`define IPFS_MAXW_RST 16'h0200
`define IPFS_MINW_RST 16'h0010
`define IPFS_LL_EXIT_RST 12'h08c
`define IPFS_LL_ENTER_RST 12'h087
`define IPFS_RESP_RST 8'hff
`define IPFS_TRANS_RST 5'h0f
`define IPFS_BAL_RST 4'h4
// ==========================================
// timing
`define IPFS_CLK_NS 40
`define IPFS_RES_NS 5
`define IPFS_AVG_NS 75000
`define IPFS_DEBOUNCE_US 9800
`define IPFS_RESTART_MS 1000
`endif

// ==== ipfs_pkg.sv ====
// types shared by the pwm supervisor
// assumes nothing beyond a systemverilog tool
package ipfs_pkg;
   typedef enum {ST_OFF, ST_RUN, ST_WAIT} ipfs_state_t;
   typedef enum logic [1:0] {
      RESP_NONE, RESP_ORING, RESP_PWM, RESP_SHUT
   } ipfs_resp_t;
   typedef enum logic [1:0] {FM_SOFT, FM_NORMAL, FM_LIGHT} ipfs_fmode_t;
   typedef struct packed {
      logic pocp;
      logic overcurrent_fault;
      logic ov;
      logic uv;
   } ipfs_flags_t;
   typedef struct packed {
      logic [15:0] fall;
      logic [15:0] rise;
   } ipfs_edge_t;
endpackage : ipfs_pkg

// ==== ipfs_stage.sv ====
// power stage model: sense words and fault pins for the pwm supervisor
// assumes the bench sets load level and fault requests
`timescale 1ns/10ps
module ipfs_stage (
   input wire logic pclk,
   input wire logic [11:0] load_level,
   input wire ipfs_pkg::ipfs_flags_t fault_req,
   input wire logic phase1_primary_drive,
   input wire logic phase2_primary_drive,
   output ipfs_pkg::ipfs_flags_t fault_pins,
   output logic [11:0] output_current_sense,
   output logic [11:0] primary_current_sense
);
   import ipfs_pkg::*;
   // ==========================================
   // sense
   initial begin
      output_current_sense = 12'h000;
      primary_current_sense = 12'h000;
   end
   always @(posedge pclk) begin
      output_current_sense <= load_level;
      // primary current flows only while a primary switch conducts
      primary_current_sense <= (phase1_primary_drive | phase2_primary_drive) ? load_level : 12'h000;
   end
   // fault comparators are asynchronous levels
   assign fault_pins = fault_req;
endmodule : ipfs_stage

// ==== testbench.sv ====
// self-checking bench for the pwm supervisor over apb
// assumes ipfs_top, ipfs_stage and the register map header
`timescale 1ns/10ps
`include "ipfs_map.svh"
module testbench;
   import ipfs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, son, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] load_level, ocs, pcs;
   ipfs_flags_t fault_req, fault_pins;
   logic p1a, p1b, p1c, p2a, p2b, p2c, fan, oring, go, irq;
   ipfs_fmode_t fm;
   int fails, total_checks, go_count, gc, c1, c2, cr, cf, c1c, c2b, c2c;
   logic [7:0] ra [5] = '{`IPFS_A_PERIOD, `IPFS_A_MAXW, `IPFS_A_MINW, `IPFS_A_RESP, `IPFS_A_DEBOUNCE};
   logic [31:0] rv [5] = '{`IPFS_PERIOD_RST, `IPFS_MAXW_RST, `IPFS_MINW_RST, `IPFS_RESP_RST, 32'h8};
   // ==========================================
   // design and far side
   ipfs_top #(.CS_W(12), .DEBOUNCE_CYC(8), .RESTART_CYC(20)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fault_pins(fault_pins), .supply_on_request(son),
      .output_current_sense(ocs), .primary_current_sense(pcs), .phase1_primary_drive(p1a),
      .phase1_rectifier_drive(p1b), .phase1_freewheel_drive(p1c), .phase2_primary_drive(p2a),
      .phase2_rectifier_drive(p2b), .phase2_freewheel_drive(p2c), .fan_drive(fan), .oring_switch(oring),
      .soft_start_go(go), .filter_mode(fm), .irq(irq));
   ipfs_stage stage (.pclk(pclk), .load_level(load_level), .fault_req(fault_req), .phase1_primary_drive(p1a),
      .phase2_primary_drive(p2a), .fault_pins(fault_pins), .output_current_sense(ocs),
      .primary_current_sense(pcs));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (go === 1'b1) go_count <= go_count + 1;
   end
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request held until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never reassigns psel in this time step
      @(posedge pclk);
   endtask : apb
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // 672 cycles is four whole periods of 168 clocks
   task automatic measure();
      wt(200);
      c1 = 0;
      c2 = 0;
      cr = 0;
      cf = 0;
      c1c = 0;
      c2b = 0;
      c2c = 0;
      repeat (672) begin
         @(negedge pclk);
         c1 += int'(p1a === 1'b1);
         c1c += int'(p1c === 1'b1);
         c2b += int'(p2b === 1'b1);
         c2c += int'(p2c === 1'b1);
         c2 += int'(p2a === 1'b1);
         cr += int'(p1b === 1'b1);
         cf += int'(fan === 1'b1);
      end
      @(posedge pclk);
   endtask : measure
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      wrap_up();
   end
   // ==========================================
   // tests
   initial begin
      {presetn, psel, penable, pwrite, son, paddr, pwdata, fault_req} = '0;
      load_level = 12'd80;
      wt(16);
      presetn <= 1'b1;
      wt(1);
      for (int i = 0; i < 5; i++) begin
         apb(0, ra[i], 0);
         chk(q, rv[i]);
      end
      apb(0, 8'h5c, 0);
      chk({err, q[30:0]}, 32'h80000000);
      for (int i = 0; i < 7; i++) apb(1, `IPFS_A_EDGE0 + 8'(4 * i), 0);
      apb(1, `IPFS_A_DEMAND, 32'h300);
      apb(1, `IPFS_A_MASK, 32'hf);
      apb(1, `IPFS_A_CTRL, 32'h1);
      son <= 1'b1;
      measure();
      chk(c1, 256);
      chk(cr, 256);
      chk(c1c, 256);
      chk(cf, 256);
      chk(c2, 0);
      apb(1, `IPFS_A_CTRL, 32'h5);
      measure();
      chk(cr, 0);
      chk(c1c, 0);
      chk(c1, 256);
      apb(1, `IPFS_A_CTRL, 32'h3);
      apb(1, `IPFS_A_DEMAND, 32'h8);
      measure();
      chk(c1, 0);
      chk(cf, 4);
      apb(1, `IPFS_A_CTRL, 32'h1);
      apb(1, `IPFS_A_DEMAND, 32'h300);
      load_level <= 12'd150;
      wt(4000);
      apb(0, `IPFS_A_STATE, 0);
      chk(q[0], 0);
      measure();
      chk(c2, 256);
      chk(c2b, 256);
      chk(c2c, 256);
      chk(fm, FM_NORMAL);
      load_level <= 12'd138;
      wt(4000);
      apb(0, `IPFS_A_STATE, 0);
      chk(q[0], 0);
      load_level <= 12'd130;
      wt(4000);
      apb(0, `IPFS_A_STATE, 0);
      chk(q[0], 1);
      chk(fm, FM_LIGHT);
      apb(1, `IPFS_A_RESP, 32'h0e);
      fault_req <= 4'b0001;
      wt(4);
      fault_req <= 4'b0000;
      measure();
      chk(c1, 256);
      apb(1, `IPFS_A_STATUS, 32'h1);
      fault_req <= 4'b0001;
      wt(4);
      fault_req <= 4'b0101;
      wt(20);
      apb(0, `IPFS_A_FIRST, 0);
      chk(q, 1);
      chk(irq, 1);
      measure();
      chk(c1, 0);
      chk(oring, 1);
      fault_req <= 4'b0000;
      wt(10);
      apb(0, `IPFS_A_STATUS, 0);
      chk(q, 5);
      apb(1, `IPFS_A_STATUS, 32'h5);
      wt(2);
      chk(irq, 0);
      measure();
      chk(c1, 256);
      fault_req <= 4'b0010;
      wt(14);
      fault_req <= 4'b0000;
      apb(0, `IPFS_A_STATE, 0);
      chk(q[3:2], 2);
      chk(oring, 0);
      chk(fm, FM_SOFT);
      gc = go_count;
      apb(1, `IPFS_A_STATUS, 32'h2);
      wt(40);
      chk(go_count - gc, 1);
      wrap_up();
   end
endmodule : testbench
